// *** shared/conv_out_defines.svh ***
// constants for the conversion output stage
`ifndef CONV_OUT_DEFINES_SVH
`define CONV_OUT_DEFINES_SVH
`define CONV_RES_W 14
`define CONV_CODE_MIN 14'h0000
`define CONV_CODE_MAX 14'h3FFF
`define CONV_PIPE_LAT 3
`define CONV_SRC_W 16
`endif

// *** shared/conv_out_pkg.sv ***
// types for the conversion output stage
package conv_out_pkg;
   typedef struct packed {
      logic out_of_range_flag;
      logic [13:0] result;
   } sample_s;
   typedef enum logic [1:0] {
      RANGE_IN,
      RANGE_UNDER,
      RANGE_OVER
   } range_e;
endpackage

// *** hdl/conv_out.sv ***
// pipelined converter output stage with out-of-range flag
// Operation
// - flag updates with its result word
// - flag and result share pipeline latency
// - flag low for in-span input
// - flag high beyond span either side
// - flag per word, valid only while out_valid_o is high; not held between words
// - timing from both sampling clock edges
// - unsigned 14-bit result, clamped at limits
`timescale 1ns/10ps
`include "conv_out_defines.svh"
module conv_out #(
   parameter int PIPE_LAT = `CONV_PIPE_LAT
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic sclk_i,
   input wire logic signed [`CONV_SRC_W-1:0] ain_i,
   input wire logic out_ready_i,
   output logic [`CONV_RES_W-1:0] result_o,
   output logic out_of_range_flag_o,
   output logic out_valid_o
);
   // the stage array and its valid vector need at least one stage
   if (PIPE_LAT < 1 || PIPE_LAT > 16) begin : g_bad_lat
      $error("PIPE_LAT out of range");
   end

   // analog stand-in: signed 16-bit, span is -8192..8191
   localparam logic signed [15:0] LO = 16'shE000;
   localparam logic signed [15:0] HI = 16'sh1FFF;

   function automatic conv_out_pkg::sample_s quantise(
      input logic signed [15:0] v);
      conv_out_pkg::sample_s s;
      s.out_of_range_flag = (v < LO) || (v > HI);
      if (v < LO)
         s.result = `CONV_CODE_MIN;
      else if (v > HI)
         s.result = `CONV_CODE_MAX;
      else
         s.result = {~v[13], v[12:0]};
      return s;
   endfunction

   // three-stage pin synchroniser for the sampling clock
   logic [2:0] sc_r, sc_nxt;
   logic sc_lvl_r, sc_lvl_nxt;
   always_comb begin
      sc_nxt = {sc_r[1:0], sclk_i};
      sc_lvl_nxt = (sc_r[2] == sc_r[1]) ? sc_r[2] : sc_lvl_r;
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sc_r <= 3'h0;
         sc_lvl_r <= 1'b0;
      end else begin
         sc_r <= sc_nxt;
         sc_lvl_r <= sc_lvl_nxt;
      end
   end
   wire logic sc_change = (sc_r[2] == sc_r[1]) && (sc_r[2] != sc_lvl_r);
   // rising edge samples, falling edge advances the pipeline
   wire logic samp_en = sc_change && sc_r[2];
   wire logic adv_en = sc_change && !sc_r[2];

   // flag and result share one struct so they cannot drift apart
   conv_out_pkg::sample_s hold_r, hold_nxt;
   conv_out_pkg::sample_s pipe_r [PIPE_LAT];
   conv_out_pkg::sample_s pipe_nxt [PIPE_LAT];
   logic [PIPE_LAT-1:0] pv_r, pv_nxt;
   logic hv_r, hv_nxt;
   logic stall;

   always_comb begin
      hold_nxt = hold_r;
      hv_nxt = hv_r;
      pipe_nxt = pipe_r;
      pv_nxt = pv_r;
      if (samp_en) begin
         hold_nxt = quantise(ain_i);
         hv_nxt = 1'b1;
      end
      // a stalled exit freezes the pipe; sample-held word waits until the next sample overwrites it
      if (adv_en && !stall) begin
         pipe_nxt[0] = hold_r;
         pv_nxt[0] = hv_r;
         hv_nxt = 1'b0;
         for (int i = 1; i < PIPE_LAT; i++) begin
            pipe_nxt[i] = pipe_r[i-1];
            pv_nxt[i] = pv_r[i-1];
         end
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         hold_r <= '0;
         hv_r <= 1'b0;
         pv_r <= '0;
         for (int i = 0; i < PIPE_LAT; i++)
            pipe_r[i] <= '0;
      end else begin
         hold_r <= hold_nxt;
         hv_r <= hv_nxt;
         pv_r <= pv_nxt;
         pipe_r <= pipe_nxt;
      end
   end

   // two-entry output buffer
   conv_out_pkg::sample_s buf_r [2], buf_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;
   wire logic push = adv_en && !stall && pv_r[PIPE_LAT-1];
   wire logic pop = out_valid_o && out_ready_i;
   assign stall = (cnt_r == 2'h2) && !out_ready_i;

   always_comb begin
      buf_nxt = buf_r;
      cnt_nxt = cnt_r;
      if (pop) begin
         buf_nxt[0] = buf_r[1];
         cnt_nxt = cnt_nxt - 2'h1;
      end
      if (push) begin
         buf_nxt[cnt_nxt[0]] = pipe_r[PIPE_LAT-1];
         cnt_nxt = cnt_nxt + 2'h1;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         buf_r[0] <= '0;
         buf_r[1] <= '0;
         cnt_r <= 2'h0;
      end else begin
         buf_r <= buf_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // registered outputs mirror the buffer head
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         result_o <= '0;
         out_of_range_flag_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         result_o <= buf_nxt[0].result;
         out_of_range_flag_o <= buf_nxt[0].out_of_range_flag;
         out_valid_o <= (cnt_nxt != 2'h0);
      end
   end

   // code and flag checks: a flag never rides on an unclamped code
   AST_CLAMP_HI: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      out_valid_o && result_o != `CONV_CODE_MAX && result_o != `CONV_CODE_MIN
      |-> !out_of_range_flag_o)
      else $error("flag set on unclamped code");
   AST_FLAG_CODE: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      hv_r && hold_r.out_of_range_flag |->
      hold_r.result == `CONV_CODE_MAX || hold_r.result == `CONV_CODE_MIN)
      else $error("flagged sample not clamped");
   AST_SAMPLE: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      samp_en && (ain_i > HI) |=> hold_r.out_of_range_flag
      && hold_r.result == `CONV_CODE_MAX)
      else $error("overrange sample wrong");
   AST_UNDER: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      samp_en && (ain_i < LO) |=> hold_r.out_of_range_flag
      && hold_r.result == `CONV_CODE_MIN)
      else $error("underrange sample wrong");
   AST_INSPAN: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      samp_en && (ain_i >= LO) && (ain_i <= HI) |=>
      !hold_r.out_of_range_flag)
      else $error("in-span sample flagged");
   AST_PAIR: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      adv_en && !stall |=> pipe_r[0] == $past(hold_r))
      else $error("stage zero lost pairing");
   AST_EDGES: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      !(samp_en && adv_en))
      else $error("both edges in one cycle");
   AST_HOLD: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(result_o)
      && $stable(out_of_range_flag_o))
      else $error("output changed under stall");
   // edge strobes must be single pulses or a sample would be taken twice
   AST_SAMP_PULSE: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      samp_en |=> !samp_en)
      else $error("sample strobe longer than one cycle");
   AST_ADV_PULSE: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      adv_en |=> !adv_en)
      else $error("advance strobe longer than one cycle");
   AST_HOLD_TAKEN: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      adv_en && !stall |=> !hv_r)
      else $error("held sample not taken by the pipe");
   AST_STAGE_FLAG: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      pv_r[PIPE_LAT-1] && pipe_r[PIPE_LAT-1].out_of_range_flag |->
      pipe_r[PIPE_LAT-1].result == `CONV_CODE_MAX
      || pipe_r[PIPE_LAT-1].result == `CONV_CODE_MIN)
      else $error("flag parted from its code in the pipe");
   AST_PUSH_HEAD: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      push && cnt_r == 2'h0 |=>
      {out_of_range_flag_o, result_o} == $past(pipe_r[PIPE_LAT-1]))
      else $error("output word differs from last stage");
   AST_OUT_PAIR: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      out_valid_o |-> {out_of_range_flag_o, result_o} == buf_r[0])
      else $error("output word differs from buffer head");
   AST_VALID_CNT: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      out_valid_o == (cnt_r != 2'h0) && cnt_r != 2'h3)
      else $error("valid and buffer count disagree");
   // a single-stage pipe has no inner shift to watch
   if (PIPE_LAT > 1) begin : g_shift_chk
      AST_SHIFT: assert property (@(posedge mclk_i)
         disable iff (!rst_n_i)
         adv_en && !stall |=> pipe_r[1] == $past(pipe_r[0])
         && pv_r[1] == $past(pv_r[0]))
         else $error("pipeline shift lost a sample");
   end
endmodule

// *** verif/conv_rx_model.sv ***
// receiver model: captures word and flag together, decodes range
`timescale 1ns/10ps
module conv_rx_model (
   input wire logic mclk_i,
   input wire logic stall_i,
   input wire logic [13:0] result_i,
   input wire logic out_of_range_flag_i,
   input wire logic out_valid_i,
   output logic out_ready_o,
   output conv_out_pkg::sample_s word_o,
   output conv_out_pkg::range_e range_o,
   output logic [13:0] signed_o,
   output logic got_o
);
   logic [1:0] phase_r = 2'h0;
   always_ff @(posedge mclk_i) begin
      phase_r <= phase_r + 2'h1;
      got_o <= out_valid_i && out_ready_o;
      if (out_valid_i && out_ready_o) begin
         word_o <= {out_of_range_flag_i, result_i};
      end
   end
   // slow mode accepts one cycle in four, still above sample rate
   assign out_ready_o = !stall_i || (phase_r == 2'h3);
   assign range_o = !word_o.out_of_range_flag ? conv_out_pkg::RANGE_IN :
      word_o.result[13] ? conv_out_pkg::RANGE_OVER :
      conv_out_pkg::RANGE_UNDER;
   assign signed_o = {~word_o.result[13], word_o.result[12:0]};
endmodule

// *** verif/test_conv_out.sv ***
// bench for the converter output stage
`timescale 1ns/10ps
module test_conv_out;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk = 1'b0;
   logic stall = 1'b0;
   logic signed [15:0] ain = 16'sh0000;
   logic [13:0] res;
   logic flag, valid, rdy, got;
   conv_out_pkg::sample_s word, eq[$];
   conv_out_pkg::range_e rng, rq[$];
   logic [13:0] sgn, sq[$];
   int err_total = 0;
   int samples_checked = 0;
   typedef logic signed [15:0] tbl_t [5];
   always #20 mclk = ~mclk;
   conv_out #(.PIPE_LAT(3)) DUT (.mclk_i(mclk), .rst_n_i(rst_n),
      .sclk_i(sclk), .ain_i(ain), .out_ready_i(rdy), .result_o(res),
      .out_of_range_flag_o(flag), .out_valid_o(valid));
   conv_rx_model RX (.mclk_i(mclk), .stall_i(stall), .result_i(res),
      .out_of_range_flag_i(flag), .out_valid_i(valid), .out_ready_o(rdy),
      .word_o(word), .range_o(rng), .signed_o(sgn), .got_o(got));
   task automatic finish_test;
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(negedge mclk) begin
      conv_out_pkg::sample_s e;
      conv_out_pkg::range_e r;
      logic [13:0] s;
      if (got === 1'b1 && eq.size() == 0) begin
         err_total++;
         $display("Error word expected none seen %h", word);
      end else if (got === 1'b1) begin
         e = eq.pop_front();
         r = rq.pop_front();
         s = sq.pop_front();
         samples_checked++;
         if (word !== e || rng !== r) begin
            err_total++;
            $display("Error word expected %h/%0d seen %h/%0d", e, r,
               word, rng);
         end
         if (sgn !== s) begin
            err_total++;
            $display("Error signed expected %h seen %h", s, sgn);
         end
      end
   end
   // one full sampling period, both edges, 5 mclk each half
   task automatic smp(input logic signed [15:0] v);
      logic hi, lo;
      hi = v > 16'sh1FFF;
      lo = v < 16'shE000;
      eq.push_back({hi | lo, hi ? 14'h3FFF : lo ? 14'h0000 :
         14'(v + 16'sh2000)});
      sq.push_back(hi ? 14'h1FFF : lo ? 14'h2000 : v[13:0]);
      rq.push_back(hi ? conv_out_pkg::RANGE_OVER : lo ?
         conv_out_pkg::RANGE_UNDER : conv_out_pkg::RANGE_IN);
      ain = v;
      sclk = 1'b1;
      repeat (5) @(negedge mclk);
      sclk = 1'b0;
      repeat (5) @(negedge mclk);
   endtask
   task automatic run(input tbl_t t);
      foreach (t[i]) smp(t[i]);
      repeat (4) smp(16'sh0000);
      // slow receiver may need four cycles to drain the last word
      repeat (4) @(negedge mclk);
      if (eq.size() != 3) begin
         err_total++;
         $display("Error backlog expected 3 seen %0d", eq.size());
      end
   endtask
   task automatic t_span;
      run('{16'shE000, 16'sh0000, 16'sh1FFF, 16'sh1234, 16'shF000});
   endtask
   task automatic t_beyond;
      run('{16'sh2000, 16'sh7FFF, 16'shDFFF, 16'sh8000, 16'sh2000});
   endtask
   task automatic t_recover;
      run('{16'sh4000, 16'shC000, 16'sh0100, 16'sh2001, 16'sh1FFF});
   endtask
   task automatic t_stall;
      stall = 1'b1;
      t_beyond();
      t_recover();
      stall = 1'b0;
   endtask
   initial begin
      #2000000;
      err_total++;
      finish_test();
   end
   initial begin
      repeat (6) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_span();
      t_beyond();
      t_recover();
      t_stall();
      finish_test();
   end
endmodule
